// ### bank_track.sv
/*
 * eight-bank command legality tracker for a low-power ddr device.
 * assumes the command/address pins are already decoded into a command
 * carrier on clk_sys; clock enable and write beats arrive as pins.
 */
// Contract
// - nop leaves bank state and operation unchanged
// - idle after precharge plus precharge time, or after register write time
// - active after activate plus column delay
// - plain read/write enter reading/writing
// - register read lasts read time, then returns
// - register write lasts write time, then idle
// - auto precharge on or off both accepted
// - register read allowed mid activate or precharge
// - bank returns per state when read issued
// - reset via register write from power on; here a separate reset command does it, register write needs every bank idle
// - activate elsewhere opens row in bank m
// - read/write elsewhere starts burst in bank m
// - mask high drops lane, low stores it
`timescale 1ns/100ps
module bank_track (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // command side
    input wire logic clk_enable,
    input bank_track_pkg::cmd_s cmd_in,
    // write data side
    input bank_track_pkg::wr_beat_s wr_beat,
    // state and stored data
    output bank_track_pkg::bank_state_e bank_state [bank_track_pkg::NUM_BANKS],
    output logic [bank_track_pkg::DATA_W-1:0] wr_data_out,
    output logic wr_data_valid,
    output logic illegal_cmd
);

    // ----------------------------------------------------------------
    // clock enable sampling
    // ----------------------------------------------------------------
    logic cke_meta_q, cke_meta_d, cke_sync_q, cke_sync_d, cke_prev_q, cke_prev_d;
    logic cmd_live;

    always_comb begin
        cke_meta_d = clk_enable;
        cke_sync_d = cke_meta_q;
        cke_prev_d = cke_sync_q;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cke_meta_q <= 1'b0;
            cke_sync_q <= 1'b0;
            cke_prev_q <= 1'b0;
        end else begin
            cke_meta_q <= cke_meta_d;
            cke_sync_q <= cke_sync_d;
            cke_prev_q <= cke_prev_d;
        end
    end

    // commands count only with enable high now and on the previous edge
    assign cmd_live = cmd_in.valid && cke_sync_q && cke_prev_q;

    // ----------------------------------------------------------------
    // per-bank trackers
    // ----------------------------------------------------------------
    logic [bank_track_pkg::NUM_BANKS-1:0] hit;
    logic all_idle, any_mr_busy, any_burst, all_pre_ok;

    always_comb begin
        all_idle = 1'b1;
        any_mr_busy = 1'b0;
        any_burst = 1'b0;
        all_pre_ok = 1'b1;
        for (int i = 0; i < bank_track_pkg::NUM_BANKS; i++) begin
            all_idle &= (bank_state[i] == bank_track_pkg::ST_IDLE);
            any_mr_busy |= (bank_state[i] inside {bank_track_pkg::ST_IDLE_MRR, bank_track_pkg::ST_ACTIVE_MRR,
                                                  bank_track_pkg::ST_RESETTING_MRR, bank_track_pkg::ST_MRW});
            any_burst |= (bank_state[i] inside {bank_track_pkg::ST_READING, bank_track_pkg::ST_WRITING,
                                                bank_track_pkg::ST_READING_AP, bank_track_pkg::ST_WRITING_AP});
            all_pre_ok &= !(bank_state[i] inside {bank_track_pkg::ST_READING_AP, bank_track_pkg::ST_WRITING_AP,
                                                   bank_track_pkg::ST_ACTIVATING, bank_track_pkg::ST_POWER_ON});
        end
    end

    // device-wide commands reach every bank, others only the addressed one
    always_comb begin
        for (int i = 0; i < bank_track_pkg::NUM_BANKS; i++) begin
            hit[i] = cmd_live && !illegal_cmd && (
                cmd_in.cmd inside {bank_track_pkg::CMD_MODE_REG_WRITE, bank_track_pkg::CMD_RESET,
                                   bank_track_pkg::CMD_MODE_REG_READ}
                || (cmd_in.cmd == bank_track_pkg::CMD_PRECHARGE && cmd_in.all_banks)
                || cmd_in.bank == i[bank_track_pkg::BANK_W-1:0]);
        end
    end

    for (genvar g = 0; g < bank_track_pkg::NUM_BANKS; g++) begin : g_bank
        bank_fsm u_bank (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .hit(hit[g]),
            .cmd(cmd_in),
            .state(bank_state[g])
        );
    end

    // ----------------------------------------------------------------
    // legality check
    // ----------------------------------------------------------------
    bank_track_pkg::bank_state_e tgt;
    assign tgt = bank_state[cmd_in.bank];

    always_comb begin
        illegal_cmd = 1'b0;
        if (cmd_live && cmd_in.cmd != bank_track_pkg::CMD_NOP) begin
            // only a nop while any register access runs
            if (any_mr_busy) begin
                illegal_cmd = 1'b1;
            end else begin
                case (cmd_in.cmd)
                    bank_track_pkg::CMD_ACTIVATE:
                        illegal_cmd = (tgt != bank_track_pkg::ST_IDLE);
                    bank_track_pkg::CMD_READ, bank_track_pkg::CMD_WRITE:
                        illegal_cmd = !(tgt inside {bank_track_pkg::ST_ACTIVE, bank_track_pkg::ST_READING,
                                                    bank_track_pkg::ST_WRITING});
                    bank_track_pkg::CMD_PRECHARGE:
                        illegal_cmd = cmd_in.all_banks ? !all_pre_ok
                            : (tgt inside {bank_track_pkg::ST_READING_AP, bank_track_pkg::ST_WRITING_AP,
                                           bank_track_pkg::ST_ACTIVATING, bank_track_pkg::ST_POWER_ON});
                    bank_track_pkg::CMD_MODE_REG_READ:
                        illegal_cmd = any_burst || (tgt == bank_track_pkg::ST_POWER_ON);
                    bank_track_pkg::CMD_MODE_REG_WRITE:
                        illegal_cmd = !all_idle;
                    bank_track_pkg::CMD_RESET:
                        illegal_cmd = any_burst;
                    default:
                        illegal_cmd = 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // write data masking
    // ----------------------------------------------------------------
    logic [bank_track_pkg::DATA_W-1:0] wr_data_q, wr_data_d;
    logic wr_valid_q, wr_valid_d;

    // a masked lane keeps its old content, so the store is never a blind overwrite
    always_comb begin
        wr_data_d = wr_data_q;
        wr_valid_d = wr_beat.valid;
        if (wr_beat.valid) begin
            for (int l = 0; l < bank_track_pkg::BYTE_LANES; l++) begin
                if (!wr_beat.write_data_mask[l]) begin
                    wr_data_d[l*8 +: 8] = wr_beat.data[l*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_data_q <= 16'h0000;
            wr_valid_q <= 1'b0;
        end else begin
            wr_data_q <= wr_data_d;
            wr_valid_q <= wr_valid_d;
        end
    end

    assign wr_data_out = wr_data_q;
    assign wr_data_valid = wr_valid_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_act_cmd(int b);
        hit[b] && cmd_in.cmd == bank_track_pkg::CMD_ACTIVATE;
    endsequence

    a_nop_holds_state: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cmd_live && cmd_in.cmd == bank_track_pkg::CMD_NOP && bank_state[0] == bank_track_pkg::ST_ACTIVE)
        |=> bank_state[0] == bank_track_pkg::ST_ACTIVE)
        else $error("nop changed an active bank");

    a_cke_gates_cmd: assert property (@(posedge clk_sys) disable iff (!resetn)
        !cke_prev_q |-> hit == '0)
        else $error("command taken without clock enable history");

    a_act_then_active: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_act_cmd(0) |=> bank_state[0] == bank_track_pkg::ST_ACTIVATING
        ##[1:30] bank_state[0] == bank_track_pkg::ST_ACTIVE)
        else $error("activate did not reach active");

    a_pre_to_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        (hit[1] && cmd_in.cmd == bank_track_pkg::CMD_PRECHARGE)
        |=> bank_state[1] == bank_track_pkg::ST_PRECHARGING ##[1:30] bank_state[1] == bank_track_pkg::ST_IDLE)
        else $error("precharge did not end idle");

    a_read_state: assert property (@(posedge clk_sys) disable iff (!resetn)
        (hit[2] && cmd_in.cmd == bank_track_pkg::CMD_READ && !cmd_in.auto_pre)
        |=> bank_state[2] == bank_track_pkg::ST_READING)
        else $error("read did not enter reading");

    a_mrw_len: assert property (@(posedge clk_sys) disable iff (!resetn)
        (hit[0] && cmd_in.cmd == bank_track_pkg::CMD_MODE_REG_WRITE)
        |=> bank_state[0] == bank_track_pkg::ST_MRW [*8] ##[1:5] bank_state[0] == bank_track_pkg::ST_IDLE)
        else $error("register write length wrong");

    a_mrr_busy_nop: assert property (@(posedge clk_sys) disable iff (!resetn)
        (any_mr_busy && cmd_live && cmd_in.cmd != bank_track_pkg::CMD_NOP) |-> illegal_cmd && hit == '0)
        else $error("command accepted during register access");

    a_mrw_needs_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cmd_live && cmd_in.cmd == bank_track_pkg::CMD_MODE_REG_WRITE && !all_idle) |-> illegal_cmd)
        else $error("register write accepted with busy bank");

    a_mask_lane: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_beat.valid && wr_beat.write_data_mask[0]) |=> wr_data_q[7:0] == $past(wr_data_q[7:0]))
        else $error("masked lane was written");

    a_reset_cmd: assert property (@(posedge clk_sys) disable iff (!resetn)
        (hit[3] && cmd_in.cmd == bank_track_pkg::CMD_RESET) |=> bank_state[3] == bank_track_pkg::ST_RESETTING)
        else $error("reset did not enter resetting");
endmodule

// ### bank_track_pkg.sv
/*
 * shared definitions for the eight-bank command legality tracker:
 * command codes, bank states, decoded command carrier, timing counts.
 * assumes a 20 MHz system clock; all times are converted to cycles here.
 */
package bank_track_pkg;

    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int BYTE_LANES = 2;
    localparam int DATA_W = 16;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int ROW_PRECHARGE_TIME_NS = 18;
    localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 18;
    localparam int MODE_REG_READ_TIME_NS = 200;
    localparam int MODE_REG_WRITE_TIME_NS = 500;
    localparam int BURST_LEN = 8;

    // least times round up, never below one cycle
    localparam int RP_CYC_RAW = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCD_CYC_RAW = (ACTIVATE_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MRR_CYC_RAW = (MODE_REG_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MRW_CYC_RAW = (MODE_REG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC = (RP_CYC_RAW < 1) ? 1 : RP_CYC_RAW;
    localparam int RCD_CYC = (RCD_CYC_RAW < 1) ? 1 : RCD_CYC_RAW;
    localparam int MRR_CYC = (MRR_CYC_RAW < 1) ? 1 : MRR_CYC_RAW;
    localparam int MRW_CYC = (MRW_CYC_RAW < 1) ? 1 : MRW_CYC_RAW;
    // burst of eight beats at double rate occupies four clocks
    localparam int BURST_CYC = BURST_LEN / 2;

    localparam int CNT_W = 5;

    // --------------------------------------------------------------
    // commands and states
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_ACTIVATE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_MODE_REG_READ,
        CMD_MODE_REG_WRITE,
        CMD_RESET
    } cmd_e;

    typedef enum logic [3:0] {
        ST_POWER_ON,
        ST_IDLE,
        ST_ACTIVATING,
        ST_ACTIVE,
        ST_READING,
        ST_WRITING,
        ST_READING_AP,
        ST_WRITING_AP,
        ST_PRECHARGING,
        ST_RESETTING,
        ST_IDLE_MRR,
        ST_ACTIVE_MRR,
        ST_RESETTING_MRR,
        ST_MRW
    } bank_state_e;

    typedef struct packed {
        logic valid;
        cmd_e cmd;
        logic [BANK_W-1:0] bank;
        logic all_banks;
        logic auto_pre;
    } cmd_s;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
        logic [BYTE_LANES-1:0] write_data_mask;
    } wr_beat_s;

endpackage

// ### bank_fsm.sv
/*
 * one bank's state tracker with its own timer.
 * assumes commands arrive already decoded and gated by clock enable.
 */
`timescale 1ns/100ps
module bank_fsm (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // command addressed to this bank
    input wire logic hit,
    input bank_track_pkg::cmd_s cmd,
    // state out
    output bank_track_pkg::bank_state_e state
);
    bank_track_pkg::bank_state_e state_q, state_d, ret_q, ret_d;
    logic [bank_track_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [bank_track_pkg::CNT_W-1:0] pend_q, pend_d;

    function automatic logic [bank_track_pkg::CNT_W-1:0] cyc(input int n);
        cyc = n[bank_track_pkg::CNT_W-1:0];
    endfunction

    always_comb begin
        state_d = state_q;
        ret_d = ret_q;
        pend_d = (pend_q != '0) ? pend_q - 1'b1 : pend_q;
        cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
        if (hit && cmd.cmd != bank_track_pkg::CMD_NOP) begin
            case (cmd.cmd)
                bank_track_pkg::CMD_ACTIVATE: begin
                    state_d = bank_track_pkg::ST_ACTIVATING;
                    cnt_d = cyc(bank_track_pkg::RCD_CYC);
                end
                bank_track_pkg::CMD_READ, bank_track_pkg::CMD_WRITE: begin
                    // either auto precharge form is accepted
                    if (cmd.auto_pre) begin
                        state_d = (cmd.cmd == bank_track_pkg::CMD_READ) ? bank_track_pkg::ST_READING_AP
                                                                       : bank_track_pkg::ST_WRITING_AP;
                        cnt_d = cyc(bank_track_pkg::BURST_CYC + bank_track_pkg::RP_CYC);
                    end else begin
                        state_d = (cmd.cmd == bank_track_pkg::CMD_READ) ? bank_track_pkg::ST_READING
                                                                       : bank_track_pkg::ST_WRITING;
                        cnt_d = cyc(bank_track_pkg::BURST_CYC);
                    end
                end
                bank_track_pkg::CMD_PRECHARGE: begin
                    state_d = bank_track_pkg::ST_PRECHARGING;
                    cnt_d = cyc(bank_track_pkg::RP_CYC);
                end
                bank_track_pkg::CMD_MODE_REG_READ: begin
                    // remember where to return, including an unfinished activate or precharge
                    case (state_q)
                        bank_track_pkg::ST_RESETTING: begin
                            state_d = bank_track_pkg::ST_RESETTING_MRR;
                            ret_d = bank_track_pkg::ST_RESETTING;
                        end
                        bank_track_pkg::ST_ACTIVE, bank_track_pkg::ST_ACTIVATING: begin
                            state_d = bank_track_pkg::ST_ACTIVE_MRR;
                            ret_d = bank_track_pkg::ST_ACTIVE;
                        end
                        default: begin
                            state_d = bank_track_pkg::ST_IDLE_MRR;
                            ret_d = bank_track_pkg::ST_IDLE;
                        end
                    endcase
                    pend_d = cnt_q;
                    cnt_d = cyc(bank_track_pkg::MRR_CYC);
                end
                bank_track_pkg::CMD_MODE_REG_WRITE: begin
                    state_d = bank_track_pkg::ST_MRW;
                    cnt_d = cyc(bank_track_pkg::MRW_CYC);
                end
                bank_track_pkg::CMD_RESET: begin
                    state_d = bank_track_pkg::ST_RESETTING;
                    cnt_d = '0;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end else if (cnt_q == cyc(1) || (cnt_q == '0 && pend_q == '0)) begin
            // a nop only lets the running operation continue
            case (state_q)
                bank_track_pkg::ST_ACTIVATING: state_d = bank_track_pkg::ST_ACTIVE;
                bank_track_pkg::ST_PRECHARGING, bank_track_pkg::ST_READING_AP,
                bank_track_pkg::ST_WRITING_AP, bank_track_pkg::ST_MRW: state_d = bank_track_pkg::ST_IDLE;
                bank_track_pkg::ST_READING, bank_track_pkg::ST_WRITING: state_d = bank_track_pkg::ST_ACTIVE;
                bank_track_pkg::ST_IDLE_MRR, bank_track_pkg::ST_ACTIVE_MRR,
                bank_track_pkg::ST_RESETTING_MRR: begin
                    // an activate or precharge must still finish its own delay
                    state_d = ret_q;
                    if (pend_q > cyc(bank_track_pkg::MRR_CYC)) begin
                        cnt_d = pend_q - cyc(bank_track_pkg::MRR_CYC);
                        state_d = (ret_q == bank_track_pkg::ST_ACTIVE) ? bank_track_pkg::ST_ACTIVATING
                                                                      : bank_track_pkg::ST_PRECHARGING;
                    end
                    pend_d = '0;
                end
                default: state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= bank_track_pkg::ST_POWER_ON;
            ret_q <= bank_track_pkg::ST_IDLE;
            cnt_q <= '0;
            pend_q <= '0;
        end else begin
            state_q <= state_d;
            ret_q <= ret_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
        end
    end

    assign state = state_q;
endmodule

// ### cmd_driver.sv
/*
 * controller-side partner: raises clock enable, issues decoded commands
 * and write beats one at a time, each followed by a nop cycle.
 * assumes the caller orders commands legally and waits out bank timers.
 */
`timescale 1ns/100ps
module cmd_driver #(
    parameter int ACT_GAP = 2
) (
    // clock
    input wire logic clk_sys,
    // drive side
    output logic clk_enable,
    output bank_track_pkg::cmd_s cmd_in,
    output bank_track_pkg::wr_beat_s wr_beat,
    // device flag
    input wire logic illegal_cmd
);
    // ------------------------------------------------------------
    // driver tasks
    // ------------------------------------------------------------
    int cyc = 0;
    int act_at = -100;
    initial begin
        clk_enable = 1'b0;
        cmd_in = '0;
        wr_beat = '0;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;

    // two sync flops plus the previous-edge check need three edges
    task automatic start();
        @(posedge clk_sys);
        clk_enable <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic send(input bank_track_pkg::cmd_e c, input logic [2:0] b, input logic ap, input logic all,
                        output logic flag);
        // activate spacing is held here, the device never checks it
        while (c == bank_track_pkg::CMD_ACTIVATE && cyc - act_at < ACT_GAP) @(posedge clk_sys);
        @(posedge clk_sys);
        cmd_in <= '{1'b1, c, b, all, ap};
        if (c == bank_track_pkg::CMD_ACTIVATE) act_at = cyc;
        #1 flag = illegal_cmd;
        @(posedge clk_sys);
        // a nop follows every command; caller waits bursts and timers out
        cmd_in <= '0;
    endtask

    task automatic beat(input logic [15:0] d, input logic [1:0] m);
        @(posedge clk_sys);
        wr_beat <= '{1'b1, d, m};
        @(posedge clk_sys);
        // released lanes show the inverse so stale data cannot pass
        wr_beat <= '{1'b0, ~d, ~m};
    endtask
endmodule

// ### multibank_command_legality_tb_top.sv
/*
 * self-checking bench for the bank tracker: each scenario is one task.
 * assumes the partner model cmd_driver and the tracker's package timings.
 */
`timescale 1ns/100ps
module multibank_command_legality_tb_top;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clk_enable;
    bank_track_pkg::cmd_s cmd_in;
    bank_track_pkg::wr_beat_s wr_beat;
    bank_track_pkg::bank_state_e bank_state [bank_track_pkg::NUM_BANKS];
    logic [15:0] wr_data_out;
    logic wr_data_valid;
    logic illegal_cmd;
    logic flag;
    int n_fail = 0;
    int checks = 0;

    always #25 clk_sys = ~clk_sys;

    bank_track bank_track_i (.clk_sys(clk_sys), .resetn(resetn), .clk_enable(clk_enable), .cmd_in(cmd_in),
        .wr_beat(wr_beat), .bank_state(bank_state), .wr_data_out(wr_data_out),
        .wr_data_valid(wr_data_valid), .illegal_cmd(illegal_cmd));
    cmd_driver cmd_driver_i (.clk_sys(clk_sys), .clk_enable(clk_enable), .cmd_in(cmd_in), .wr_beat(wr_beat),
        .illegal_cmd(illegal_cmd));

    task automatic end_sim();
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            $display("Error %s expected %0h seen %0h", name, exp, seen);
            n_fail++;
        end
    endtask

    task automatic st(input int b, input bank_track_pkg::bank_state_e exp);
        chk($sformatf("bank_state[%0d]", b), 16'(exp), 16'(bank_state[b]));
    endtask

    task automatic st_all(input bank_track_pkg::bank_state_e exp);
        for (int b = 0; b < bank_track_pkg::NUM_BANKS; b++) st(b, exp);
    endtask

    task automatic cmd(input bank_track_pkg::cmd_e c, input int b, input logic ap);
        cmd_driver_i.send(c, 3'(b), ap, 1'b0, flag);
        #1;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_init();
        cmd(bank_track_pkg::CMD_RESET, 0, 1'b0);
        st_all(bank_track_pkg::ST_RESETTING);
        cmd(bank_track_pkg::CMD_MODE_REG_READ, 0, 1'b0);
        st_all(bank_track_pkg::ST_RESETTING_MRR);
        step(bank_track_pkg::MRR_CYC);
        st_all(bank_track_pkg::ST_RESETTING);
        // register write wants every bank idle, so resetting banks are precharged together first
        cmd_driver_i.send(bank_track_pkg::CMD_PRECHARGE, 3'h0, 1'b0, 1'b1, flag);
        #1;
        chk("illegal_cmd", 16'h0000, 16'(flag));
        st_all(bank_track_pkg::ST_PRECHARGING);
        step(bank_track_pkg::RP_CYC);
        st_all(bank_track_pkg::ST_IDLE);
        cmd(bank_track_pkg::CMD_MODE_REG_WRITE, 0, 1'b0);
        st_all(bank_track_pkg::ST_MRW);
        step(bank_track_pkg::MRW_CYC);
        st_all(bank_track_pkg::ST_IDLE);
    endtask

    task automatic t_open();
        cmd(bank_track_pkg::CMD_ACTIVATE, 0, 1'b0);
        chk("illegal_cmd", 16'h0000, 16'(flag));
        st(0, bank_track_pkg::ST_ACTIVATING);
        step(bank_track_pkg::RCD_CYC);
        st(0, bank_track_pkg::ST_ACTIVE);
        cmd(bank_track_pkg::CMD_ACTIVATE, 2, 1'b0);
        st(2, bank_track_pkg::ST_ACTIVATING);
        st(0, bank_track_pkg::ST_ACTIVE);
        step(bank_track_pkg::RCD_CYC + 3);
        st(2, bank_track_pkg::ST_ACTIVE);
        st(0, bank_track_pkg::ST_ACTIVE);
        cmd(bank_track_pkg::CMD_NOP, 0, 1'b0);
        st(0, bank_track_pkg::ST_ACTIVE);
        cmd(bank_track_pkg::CMD_MODE_REG_WRITE, 0, 1'b0);
        chk("illegal_cmd", 16'h0001, 16'(flag));
        st(0, bank_track_pkg::ST_ACTIVE);
    endtask

    task automatic t_burst();
        cmd(bank_track_pkg::CMD_READ, 2, 1'b0);
        st(2, bank_track_pkg::ST_READING);
        st(0, bank_track_pkg::ST_ACTIVE);
        step(bank_track_pkg::BURST_CYC);
        st(2, bank_track_pkg::ST_ACTIVE);
        cmd(bank_track_pkg::CMD_WRITE, 0, 1'b1);
        st(0, bank_track_pkg::ST_WRITING_AP);
        st(2, bank_track_pkg::ST_ACTIVE);
        cmd_driver_i.beat(16'hFFFF, 2'h0);
        #1;
        chk("wr_data_valid", 16'h0001, 16'(wr_data_valid));
        chk("wr_data_out", 16'hFFFF, wr_data_out);
        cmd_driver_i.beat(16'h1234, 2'h2);
        #1;
        chk("wr_data_out", 16'hFF34, wr_data_out);
        cmd_driver_i.beat(16'h5678, 2'h1);
        #1;
        chk("wr_data_out", 16'h5634, wr_data_out);
        step(20);
        st(0, bank_track_pkg::ST_IDLE);
    endtask

    task automatic t_mrr_pre();
        cmd(bank_track_pkg::CMD_MODE_REG_READ, 2, 1'b0);
        st(2, bank_track_pkg::ST_ACTIVE_MRR);
        st(0, bank_track_pkg::ST_IDLE_MRR);
        cmd(bank_track_pkg::CMD_ACTIVATE, 5, 1'b0);
        chk("illegal_cmd", 16'h0001, 16'(flag));
        st(5, bank_track_pkg::ST_IDLE_MRR);
        step(bank_track_pkg::MRR_CYC);
        st(2, bank_track_pkg::ST_ACTIVE);
        st(0, bank_track_pkg::ST_IDLE);
        cmd(bank_track_pkg::CMD_PRECHARGE, 2, 1'b0);
        st(2, bank_track_pkg::ST_PRECHARGING);
        step(bank_track_pkg::RP_CYC);
        st(2, bank_track_pkg::ST_IDLE);
    endtask

    // a read to an idle bank is not a listed sequence and must be refused
    task automatic t_illegal();
        cmd(bank_track_pkg::CMD_READ, 3, 1'b0);
        chk("illegal_cmd", 16'h0001, 16'(flag));
        st(3, bank_track_pkg::ST_IDLE);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        st_all(bank_track_pkg::ST_POWER_ON);
        cmd_driver_i.start();
        t_init();
        t_open();
        t_burst();
        t_mrr_pre();
        t_illegal();
        end_sim();
    end

    // any hang is cut short and reported as a mismatch
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        end_sim();
    end
endmodule
